// *** rtl/ucr_regmap.sv ***
// Channel register map and address decoder behind the serial slave port
//
// Contract
// - Offset 0 reads receive byte, writes transmit
// - Latch bit opens divisor bytes; fraction needs unlock
// - Interrupt enable bit order as listed
// - Interrupt status: source code, FIFO enabled bits
// - FIFO control: enable, resets, DMA, triggers
// - Line control read/write with listed fields
// - Modem control reachable unless key value
// - Line status is read-only datapath status
// - Modem status: deltas low, states high
// - Scratch location stores and returns host byte
// - Halt/trigger enable maps halt/resume at 6
// - Same enable maps trigger levels at 7
// - FIFO fill levels read-only, bit 7 zero
// - GPIO, reserved and extra feature offsets
// - Key value maps enhanced and flow characters
// - Enhanced bits act only while unlocked
// - Enhanced function field layout
`include "ucr_defs.svh"

module ucr_regmap
  import ucr_pkg::*;
#(
  parameter int P_LVL_W     = 7,
  parameter bit P_CHANNEL_B = 1'b1
) (
  // Clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  // Register access from the slave port
  input  wire logic [3:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rd_valid,
  // Channel datapath
  input  wire ucr_stat_t  i_stat,
  input  wire logic [3:0] i_modem_n,
  output ucr_regs_t       o_cfg,
  output ucr_evt_t        o_evt,
  output logic      [7:0] o_tx_data
);

  // Level counters wider than the 7-bit field cannot be reported
  if (P_LVL_W != 7) begin : g_chk
    $error("ucr_regmap: P_LVL_W must be 7");
  end

  // Map address plus mode bits to one register target
  function automatic ucr_sel_t ucr_decode(input logic [3:0] addr,
                                          input logic [7:0] line_control,
                                          input logic       tt_en,
                                          input logic       enh);
    logic key;
    logic dlab;
    key  = (line_control == `UCR_LCR_ENH_KEY);
    dlab = line_control[`UCR_LCR_DLAB_BIT];
    ucr_decode = UCR_SEL_NONE;
    case (addr)
      `UCR_OFF_HOLD: begin
        if (!dlab) ucr_decode = UCR_SEL_HOLD;
        else if (!key) ucr_decode = UCR_SEL_DLL;
      end
      `UCR_OFF_IER: begin
        if (!dlab) ucr_decode = UCR_SEL_IER;
        else if (!key) ucr_decode = UCR_SEL_DLM;
      end
      `UCR_OFF_ISR: begin
        if (key) ucr_decode = UCR_SEL_EFR;
        else if (!dlab) ucr_decode = UCR_SEL_ISR;
        else if (enh) ucr_decode = UCR_SEL_DLD;
      end
      `UCR_OFF_LCR:   ucr_decode = UCR_SEL_LCR;
      `UCR_OFF_MCR:   ucr_decode = key ? UCR_SEL_XON1 : UCR_SEL_MCR;
      `UCR_OFF_LSR:   ucr_decode = key ? UCR_SEL_XON2 : UCR_SEL_LSR;
      `UCR_OFF_MSR: begin
        if (key) ucr_decode = UCR_SEL_XOFF1;
        else if (tt_en) ucr_decode = UCR_SEL_TCR;
        else ucr_decode = UCR_SEL_MSR;
      end
      `UCR_OFF_SPR: begin
        if (key) ucr_decode = UCR_SEL_XOFF2;
        else if (tt_en) ucr_decode = UCR_SEL_TLR;
        else ucr_decode = UCR_SEL_SPR;
      end
      `UCR_OFF_TX_FIFO_FILL:   ucr_decode = UCR_SEL_TX_FIFO_FILL;
      `UCR_OFF_RX_FIFO_FILL:   ucr_decode = UCR_SEL_RX_FIFO_FILL;
      `UCR_OFF_GPIO_DIRECTION:   ucr_decode = UCR_SEL_GPIO_DIRECTION;
      `UCR_OFF_GPIO_PIN_STATE: ucr_decode = UCR_SEL_GPIO_PIN_STATE;
      `UCR_OFF_IOINT:   ucr_decode = UCR_SEL_IOINT;
      `UCR_OFF_IOCTL:   ucr_decode = UCR_SEL_IOCTL;
      `UCR_OFF_EXTRA_FEATURE_CONTROL:    ucr_decode = UCR_SEL_EXTRA_FEATURE_CONTROL;
      default:          ucr_decode = UCR_SEL_NONE;
    endcase
  endfunction

  // Apply the enhanced unlock to one byte: locked bits read as zero
  function automatic logic [7:0] ucr_lock(input logic [7:0] val,
                                          input logic [7:0] mask,
                                          input logic       enh);
    ucr_lock = enh ? val : (val & ~mask);
  endfunction

  ucr_state_t q;
  ucr_state_t d;
  ucr_sel_t   sel;
  logic       enh;
  logic       tt_en;
  logic [3:0] mchg;
  logic [7:0] mcr_eff;
  logic [5:0] isr_eff;

  // Next-state logic: decode, writes, read capture, modem change tracking
  always_comb begin
    d          = q;
    d.evt      = '0;
    d.rd_valid = 1'b0;
    enh        = q.regs.enhanced_function[`UCR_EFR_ENH_BIT];
    tt_en      = q.regs.modem_control[`UCR_MCR_TT_BIT];
    sel        = ucr_decode(i_addr, q.regs.line_control, tt_en, enh);

    // Modem pins come from outside, so two flops before anything looks
    d.msync1 = i_modem_n;
    d.msync2 = q.msync1;
    d.mprev  = q.msync2;
    mchg     = q.msync2 ^ q.mprev;

    // Delta bits: a change in the read cycle survives the clear
    if (i_rd && sel == UCR_SEL_MSR) begin
      d.mdelta     = mchg;
      d.evt.msr_read = 1'b1;
    end else begin
      d.mdelta = q.mdelta | mchg;
    end

    // Channel B alone keeps the infrared bit
    mcr_eff = ucr_lock(q.regs.modem_control, `UCR_MASK_MCR, enh);
    if (!P_CHANNEL_B) begin
      mcr_eff[`UCR_MCR_IR_BIT] = 1'b0;
    end
    isr_eff = enh ? i_stat.isr_src : (i_stat.isr_src & ~`UCR_MASK_ISR);

    // Host writes; locked enhanced bits are stored as zero
    if (i_wr) begin
      case (sel)
        UCR_SEL_HOLD: begin
          d.tx_data     = i_wdata;
          d.evt.tx_load = 1'b1;
        end
        UCR_SEL_DLL:     d.regs.dll = i_wdata;
        UCR_SEL_DLM:     d.regs.divisor_high = i_wdata;
        UCR_SEL_DLD:     d.regs.divisor_fraction = i_wdata;
        UCR_SEL_IER:     d.regs.interrupt_enable = ucr_lock(i_wdata, `UCR_MASK_IER, enh);
        UCR_SEL_ISR: begin
          d.regs.fifo_control = ucr_lock(i_wdata, `UCR_MASK_FCR, enh);
          // Reset bits are commands, not state: pulse and self-clear
          d.regs.fifo_control[`UCR_FCR_RXR_BIT] = 1'b0;
          d.regs.fifo_control[`UCR_FCR_TXR_BIT] = 1'b0;
          d.evt.rx_fifo_rst = i_wdata[`UCR_FCR_RXR_BIT];
          d.evt.tx_fifo_rst = i_wdata[`UCR_FCR_TXR_BIT];
        end
        UCR_SEL_EFR:     d.regs.enhanced_function = i_wdata;
        UCR_SEL_LCR:     d.regs.line_control = i_wdata;
        UCR_SEL_MCR:     d.regs.modem_control = ucr_lock(i_wdata, `UCR_MASK_MCR, enh);
        UCR_SEL_SPR:     d.regs.scratch_pad = i_wdata;
        UCR_SEL_TCR:     d.regs.flow_halt_resume = i_wdata;
        UCR_SEL_TLR:     d.regs.fifo_trigger_levels = i_wdata;
        UCR_SEL_XON1:    d.regs.xon1 = i_wdata;
        UCR_SEL_XON2:    d.regs.xon2 = i_wdata;
        UCR_SEL_XOFF1:   d.regs.xoff1 = i_wdata;
        UCR_SEL_XOFF2:   d.regs.xoff2 = i_wdata;
        UCR_SEL_GPIO_DIRECTION:   d.regs.gpio_direction = i_wdata;
        UCR_SEL_GPIO_PIN_STATE: d.regs.gpio_pin_state = i_wdata;
        UCR_SEL_IOINT:   d.regs.ioint = i_wdata;
        UCR_SEL_IOCTL:   d.regs.ioctl = i_wdata;
        UCR_SEL_EXTRA_FEATURE_CONTROL:    d.regs.extra_feature_control = i_wdata;
        // Status, level and reserved targets drop the write
        default:         d.regs = q.regs;
      endcase
    end

    // Host reads: data captured one cycle after the strobe
    if (i_rd) begin
      d.rd_valid = 1'b1;
      case (sel)
        UCR_SEL_HOLD: begin
          d.rdata      = i_stat.rx_data;
          d.evt.rx_pop = 1'b1;
        end
        UCR_SEL_DLL:     d.rdata = q.regs.dll;
        UCR_SEL_DLM:     d.rdata = q.regs.divisor_high;
        UCR_SEL_DLD:     d.rdata = q.regs.divisor_fraction;
        UCR_SEL_IER:     d.rdata = ucr_lock(q.regs.interrupt_enable, `UCR_MASK_IER, enh);
        UCR_SEL_ISR:     d.rdata = {{2{q.regs.fifo_control[`UCR_FCR_EN_BIT]}}, isr_eff};
        UCR_SEL_EFR:     d.rdata = q.regs.enhanced_function;
        UCR_SEL_LCR:     d.rdata = q.regs.line_control;
        UCR_SEL_MCR:     d.rdata = mcr_eff;
        UCR_SEL_LSR: begin
          d.rdata        = i_stat.line_status;
          d.evt.lsr_read = 1'b1;
        end
        // Upper nibble shows the pins as asserted (active-low inputs)
        UCR_SEL_MSR:     d.rdata = {~q.msync2[3], ~q.msync2[2], ~q.msync2[1],
                                    ~q.msync2[0], q.mdelta};
        UCR_SEL_SPR:     d.rdata = q.regs.scratch_pad;
        UCR_SEL_TCR:     d.rdata = q.regs.flow_halt_resume;
        UCR_SEL_TLR:     d.rdata = q.regs.fifo_trigger_levels;
        UCR_SEL_XON1:    d.rdata = q.regs.xon1;
        UCR_SEL_XON2:    d.rdata = q.regs.xon2;
        UCR_SEL_XOFF1:   d.rdata = q.regs.xoff1;
        UCR_SEL_XOFF2:   d.rdata = q.regs.xoff2;
        UCR_SEL_TX_FIFO_FILL:   d.rdata = {1'b0, i_stat.tx_lvl};
        UCR_SEL_RX_FIFO_FILL:   d.rdata = {1'b0, i_stat.rx_lvl};
        UCR_SEL_GPIO_DIRECTION:   d.rdata = q.regs.gpio_direction;
        UCR_SEL_GPIO_PIN_STATE: d.rdata = q.regs.gpio_pin_state;
        UCR_SEL_IOINT:   d.rdata = q.regs.ioint;
        UCR_SEL_IOCTL:   d.rdata = q.regs.ioctl;
        UCR_SEL_EXTRA_FEATURE_CONTROL:    d.rdata = q.regs.extra_feature_control;
        default:         d.rdata = 8'h00;
      endcase
    end

    // Configuration seen by the datapath, with locked bits forced low
    d.cfg     = q.regs;
    d.cfg.interrupt_enable = ucr_lock(q.regs.interrupt_enable, `UCR_MASK_IER, enh);
    d.cfg.fifo_control = ucr_lock(q.regs.fifo_control, `UCR_MASK_FCR, enh);
    d.cfg.modem_control = mcr_eff;
    // Fraction only counts while the unlock is on
    d.cfg.divisor_fraction = enh ? q.regs.divisor_fraction : 8'h00;
  end

  // State register; the clock enable freezes everything
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q        <= '0;
      q.msync1 <= `UCR_RST_PIN;
      q.msync2 <= `UCR_RST_PIN;
      q.mprev  <= `UCR_RST_PIN;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign o_rdata    = q.rdata;
  assign o_rd_valid = q.rd_valid;
  assign o_cfg      = q.cfg;
  assign o_evt      = q.evt;
  assign o_tx_data  = q.tx_data;

endmodule

// *** rtl/ucr_defs.svh ***
// Offsets, field positions, reset values and masks of the channel register map
`ifndef UCR_DEFS_SVH
`define UCR_DEFS_SVH

// Register offsets (4-bit address)
`define UCR_OFF_HOLD     4'h0
`define UCR_OFF_IER      4'h1
`define UCR_OFF_ISR      4'h2
`define UCR_OFF_LCR      4'h3
`define UCR_OFF_MCR      4'h4
`define UCR_OFF_LSR      4'h5
`define UCR_OFF_MSR      4'h6
`define UCR_OFF_SPR      4'h7
`define UCR_OFF_TX_FIFO_FILL    4'h8
`define UCR_OFF_RX_FIFO_FILL    4'h9
`define UCR_OFF_GPIO_DIRECTION    4'ha
`define UCR_OFF_GPIO_PIN_STATE  4'hb
`define UCR_OFF_IOINT    4'hc
`define UCR_OFF_RSVD     4'hd
`define UCR_OFF_IOCTL    4'he
`define UCR_OFF_EXTRA_FEATURE_CONTROL     4'hf

// Field positions
`define UCR_LCR_DLAB_BIT 7
`define UCR_EFR_ENH_BIT  4
`define UCR_MCR_TT_BIT   2
`define UCR_MCR_IR_BIT   6
`define UCR_FCR_EN_BIT   0
`define UCR_FCR_RXR_BIT  1
`define UCR_FCR_TXR_BIT  2

// Line control value that opens the enhanced set
`define UCR_LCR_ENH_KEY  8'hbf

// Bits that only act while the enhanced unlock is set
`define UCR_MASK_IER     8'hf0
`define UCR_MASK_FCR     8'h30
`define UCR_MASK_MCR     8'he0
`define UCR_MASK_ISR     6'h30

// Reset values
`define UCR_RST_REG      8'h00
`define UCR_RST_PIN      4'hf

`endif

// *** rtl/ucr_pkg.sv ***
// Types shared by the channel register map
package ucr_pkg;

  // Register targets picked by the address decoder
  typedef enum logic [4:0] {
    UCR_SEL_NONE, UCR_SEL_HOLD, UCR_SEL_DLL, UCR_SEL_DLM, UCR_SEL_DLD,
    UCR_SEL_IER, UCR_SEL_ISR, UCR_SEL_EFR, UCR_SEL_LCR, UCR_SEL_MCR,
    UCR_SEL_LSR, UCR_SEL_MSR, UCR_SEL_SPR, UCR_SEL_TCR, UCR_SEL_TLR,
    UCR_SEL_XON1, UCR_SEL_XON2, UCR_SEL_XOFF1, UCR_SEL_XOFF2,
    UCR_SEL_TX_FIFO_FILL, UCR_SEL_RX_FIFO_FILL, UCR_SEL_GPIO_DIRECTION, UCR_SEL_GPIO_PIN_STATE,
    UCR_SEL_IOINT, UCR_SEL_IOCTL, UCR_SEL_EXTRA_FEATURE_CONTROL
  } ucr_sel_t;

  // Software-written configuration
  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratch_pad;
    logic [7:0] dll;
    logic [7:0] divisor_high;
    logic [7:0] divisor_fraction;
    logic [7:0] enhanced_function;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
    logic [7:0] flow_halt_resume;
    logic [7:0] fifo_trigger_levels;
    logic [7:0] gpio_direction;
    logic [7:0] gpio_pin_state;
    logic [7:0] ioint;
    logic [7:0] ioctl;
    logic [7:0] extra_feature_control;
  } ucr_regs_t;

  // Status from the channel datapath
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] line_status;
    logic [5:0] isr_src;
    logic [6:0] tx_lvl;
    logic [6:0] rx_lvl;
  } ucr_stat_t;

  // One-cycle strobes toward the channel datapath
  typedef struct packed {
    logic tx_load;
    logic rx_pop;
    logic rx_fifo_rst;
    logic tx_fifo_rst;
    logic lsr_read;
    logic msr_read;
  } ucr_evt_t;

  // Whole state of the register map
  typedef struct packed {
    ucr_regs_t  regs;
    ucr_regs_t  cfg;
    ucr_evt_t   evt;
    logic [7:0] tx_data;
    logic [7:0] rdata;
    logic       rd_valid;
    logic [3:0] msync1;
    logic [3:0] msync2;
    logic [3:0] mprev;
    logic [3:0] mdelta;
  } ucr_state_t;

endpackage

// *** dv/ucr_regmap_sva.sv ***
// Concurrent checks on the ports of the channel register map
module ucr_regmap_sva
  import ucr_pkg::*;
(
  // Clock, reset, enable
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_clk_en,
  // Register access
  input wire logic [3:0] i_addr,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rd_valid,
  // Channel datapath
  input wire ucr_stat_t  i_stat,
  input wire logic [3:0] i_modem_n,
  input wire ucr_regs_t  o_cfg,
  input wire ucr_evt_t   o_evt,
  input wire logic [7:0] o_tx_data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // o_cfg lags the stored map by one edge, so skip requests right after a write
  logic wr_q;
  logic rd_ok;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) wr_q <= 1'b0;
    else if (i_clk_en) wr_q <= i_wr;
  end
  assign rd_ok = i_rd && i_clk_en && !wr_q;

  // Decoded reads and writes tied to their datapath effects, and locked bits held low in o_cfg
  property p_tx;
    i_wr && i_clk_en && !wr_q && i_addr == 4'h0 && !o_cfg.line_control[7]
      |=> o_evt.tx_load && o_tx_data == $past(i_wdata);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit load missing");
  property p_pop;
    rd_ok && i_addr == 4'h0 && !o_cfg.line_control[7] |=> o_evt.rx_pop && o_rdata == $past(i_stat.rx_data);
  endproperty
  a_pop: assert property (p_pop) else $error("receive byte read wrong");
  property p_lsr;
    rd_ok && i_addr == 4'h5 && o_cfg.line_control != 8'hbf |=> o_evt.lsr_read && o_rdata == $past(i_stat.line_status);
  endproperty
  a_lsr: assert property (p_lsr) else $error("line status read wrong");
  property p_msr;
    rd_ok && i_addr == 4'h6 && o_cfg.line_control != 8'hbf && !o_cfg.modem_control[2] |=> o_evt.msr_read;
  endproperty
  a_msr: assert property (p_msr) else $error("modem status read strobe missing");
  property p_lvl;
    rd_ok && i_addr == 4'h8 |=> o_rdata == {1'b0, $past(i_stat.tx_lvl)};
  endproperty
  a_lvl: assert property (p_lvl) else $error("transmit fill level wrong");
  property p_rsvd;
    rd_ok && i_addr == 4'hd |=> o_rd_valid && o_rdata == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_frac;
    rd_ok && i_addr == 4'h2 && o_cfg.line_control[7] && o_cfg.line_control != 8'hbf && !o_cfg.enhanced_function[4]
      |=> o_rdata == 8'h00;
  endproperty
  a_frac: assert property (p_frac) else $error("locked fraction readable");
  property p_lock;
    !o_cfg.enhanced_function[4] |-> o_cfg.interrupt_enable[7:4] == 4'h0 && o_cfg.modem_control[7:5] == 3'h0 && o_cfg.divisor_fraction == 8'h00;
  endproperty
  a_lock: assert property (p_lock) else $error("locked bits active");
  property p_frst;
    i_wr && i_clk_en && !wr_q && i_addr == 4'h2 && !o_cfg.line_control[7]
      |=> o_evt.rx_fifo_rst == $past(i_wdata[1]) && o_evt.tx_fifo_rst == $past(i_wdata[2]);
  endproperty
  a_frst: assert property (p_frst) else $error("fifo reset strobes wrong");
endmodule

// *** dv/ucr_dp_model.sv ***
// Behavioural channel datapath feeding status and modem pins to the map
module ucr_dp_model
  import ucr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // From the register map and bench
  input  wire ucr_evt_t   i_evt,
  input  wire logic [3:0] i_pins_n,
  // Toward the register map
  output ucr_stat_t       o_stat,
  output logic      [3:0] o_modem_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q;
  logic [6:0] txl_q;
  // Receive byte steps on each pop, so a missed pop shows as a repeated byte
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_q  <= 8'h5a;
      txl_q <= 7'h00;
    end else begin
      if (i_evt.rx_pop) rx_q <= rx_q + 8'h01;
      if (i_evt.tx_load) txl_q <= txl_q + 7'h01;
    end
  end
  // Fixed status codes chosen so every field has ones and zeros
  assign o_stat = '{rx_data: rx_q, line_status: 8'h61, isr_src: 6'h3c, tx_lvl: txl_q, rx_lvl: 7'h2a};
  assign o_modem_n = i_pins_n;
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the channel register map
module tb_top
  import ucr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clk, i_reset, i_clk_en, i_wr, i_rd, o_rd_valid;
  logic [3:0] i_addr, pins_n, modem_n;
  logic [7:0] i_wdata, o_rdata, o_tx_data;
  ucr_stat_t  stat;
  ucr_regs_t  o_cfg;
  ucr_evt_t   o_evt;
  int         n_errors, total_checks, cycles;
  // Plain read/write table: address, data written, value read back
  logic [3:0] ra [8] = '{4'h1, 4'h3, 4'h4, 4'h7, 4'ha, 4'hb, 4'hc, 4'hf};
  logic [7:0] rw [8] = '{8'hff, 8'h1f, 8'hfb, 8'ha5, 8'h3c, 8'hc3, 8'h5a, 8'h86};
  logic [7:0] rx [8] = '{8'h0f, 8'h1f, 8'h1b, 8'ha5, 8'h3c, 8'hc3, 8'h5a, 8'h86};

  ucr_regmap dut (.i_clk, .i_reset, .i_clk_en, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata,
    .o_rd_valid, .i_stat(stat), .i_modem_n(modem_n), .o_cfg, .o_evt, .o_tx_data);
  ucr_dp_model dp (.i_clk, .i_reset, .i_evt(o_evt), .i_pins_n(pins_n), .o_stat(stat),
    .o_modem_n(modem_n));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Requests start 1 ns after an idle edge and drop 1 ns after the taking edge;
  // the idle edge keeps a strobe from falling and rising in one time step
  // and gives the datapath model time to step after a pop
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    i_addr  = a;
    i_wdata = d;
    i_wr    = 1'b1;
    @(posedge i_clk);
    #1 i_wr = 1'b0;
  endtask
  // A read without its valid pulse fails against any expected byte
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    #1;
    i_addr = a;
    i_rd   = 1'b1;
    @(posedge i_clk);
    #1 i_rd = 1'b0;
    check(o_rd_valid ? o_rdata : ~exp, exp);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Hang guard, well above the roughly 170 cycles the tests need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    {i_reset, i_clk_en, i_wr, i_rd, i_addr, i_wdata, pins_n} = {2'b11, 2'b00, 4'h0, 8'h00, 4'hf};
    repeat (10) @(posedge i_clk);
    #1 i_reset = 1'b0;
    for (int i = 0; i < 8; i++) rdc(ra[i], 8'h00);
    rdc(4'hd, 8'h00);
    for (int i = 0; i < 8; i++) wr(ra[i], rw[i]);
    for (int i = 0; i < 8; i++) rdc(ra[i], rx[i]);
    $display("test plain registers done");
    // A request while the enable is low must leave no trace
    i_clk_en = 1'b0;
    wr(4'h7, 8'h00);
    i_clk_en = 1'b1;
    rdc(4'h7, 8'ha5);
    wr(4'h0, 8'h3e);
    check({7'h00, o_evt.tx_load}, 8'h01);
    check(o_tx_data, 8'h3e);
    rdc(4'h0, 8'h5a);
    rdc(4'h0, 8'h5b);
    wr(4'h5, 8'hff);
    wr(4'h8, 8'hff);
    wr(4'hd, 8'hff);
    rdc(4'h5, 8'h61);
    rdc(4'h8, 8'h01);
    rdc(4'h9, 8'h2a);
    rdc(4'hd, 8'h00);
    wr(4'h2, 8'h01);
    rdc(4'h2, 8'hcc);
    wr(4'h2, 8'h07);
    check({6'h00, o_evt.tx_fifo_rst, o_evt.rx_fifo_rst}, 8'h03);
    $display("test data path and status done");
    wr(4'h4, 8'h04);
    rdc(4'h6, 8'h00);
    wr(4'h6, 8'ha5);
    wr(4'h7, 8'h3c);
    rdc(4'h6, 8'ha5);
    rdc(4'h7, 8'h3c);
    wr(4'h4, 8'h00);
    rdc(4'h7, 8'ha5);
    pins_n = 4'h5;
    repeat (6) @(posedge i_clk);
    #1 rdc(4'h6, 8'haa);
    rdc(4'h6, 8'ha0);
    $display("test modem and flow levels done");
    wr(4'h3, 8'h80);
    wr(4'h0, 8'h12);
    check({7'h00, o_evt.tx_load}, 8'h00);
    wr(4'h1, 8'h34);
    wr(4'h2, 8'h77);
    rdc(4'h0, 8'h12);
    rdc(4'h1, 8'h34);
    rdc(4'h2, 8'h00);
    wr(4'h3, 8'hbf);
    wr(4'h2, 8'hd4);
    for (int i = 4; i < 8; i++) wr(i[3:0], 8'h10 + i[7:0]);
    rdc(4'h2, 8'hd4);
    for (int i = 4; i < 8; i++) rdc(i[3:0], 8'h10 + i[7:0]);
    wr(4'h3, 8'h80);
    wr(4'h2, 8'h77);
    rdc(4'h2, 8'h77);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'hff);
    wr(4'h4, 8'he0);
    rdc(4'h1, 8'hff);
    rdc(4'h4, 8'he0);
    rdc(4'h2, 8'hfc);
    rdc(4'h3, 8'h00);
    // Effective configuration toward the datapath, long settled by now
    check(o_cfg.interrupt_enable, 8'hff);
    check(o_cfg.divisor_fraction, 8'h77);
    check(o_cfg.fifo_control, 8'h01);
    check(o_cfg.modem_control, 8'he0);
    $display("test divisor and enhanced set done");
    report_and_stop();
  end
endmodule

bind ucr_regmap ucr_regmap_sva sva (.i_clk, .i_reset, .i_clk_en, .i_addr, .i_wr, .i_rd,
  .i_wdata, .o_rdata, .o_rd_valid, .i_stat, .i_modem_n, .o_cfg, .o_evt, .o_tx_data);
